// ==== serial_link_if.sv ====
`timescale 1ns/100ps
interface serial_link_if;
    logic dataLine;
    logic devClkOut;
    logic devClkOe;
    logic srcClkOut;
    logic srcClkOe;
    wire  linkClk;
    // Clock wire: the enabled end drives it, otherwise it rests low
    assign linkClk = devClkOe ? devClkOut : (srcClkOe ? srcClkOut : 1'b0);
    modport device (input dataLine, input linkClk, output devClkOut, output devClkOe);
    modport source (output dataLine, output srcClkOut, output srcClkOe, input linkClk);
endinterface : serial_link_if

// ==== serial_link_properties.sv ====
`timescale 1ns/100ps
// ****************
// Link wire checks
// ****************
module serial_link_properties (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic dataLine,
    input wire logic devClkOut,
    input wire logic devClkOe,
    input wire logic srcClkOut,
    input wire logic srcClkOe,
    input wire logic linkClk
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // A low bit on the wire lasts at least eight cycles at the bench rates
    sequence low_run;
        !dataLine [*8];
    endsequence
    a_clk_wire_mux: assert property (linkClk == (devClkOe ? devClkOut : srcClkOe & srcClkOut))
        else $error("link clock not from enabled end");
    a_one_clk_driver: assert property (!(devClkOe && srcClkOe))
        else $error("both ends drive the clock");
    a_reset_idle: assert property ($rose(rstn) |-> dataLine && !devClkOe && !devClkOut)
        else $error("link not idle after reset");
    a_master_clk_rest: assert property (!devClkOe && $past(!devClkOe) |-> !devClkOut)
        else $error("master clock moves while disabled");
    a_async_bit_hold: assert property ($fell(dataLine) && !devClkOe |-> low_run)
        else $error("line low shorter than a bit");
    a_slave_data_stable: assert property (srcClkOe && srcClkOut |-> $stable(dataLine))
        else $error("data moved while clock high");
    a_follow_data_low: assert property (devClkOe && $changed(dataLine) |-> !devClkOut)
        else $error("data moved while master clock high");
    a_master_clk_bound: assert property (devClkOe && $rose(devClkOut) |-> ##[1:300] !devClkOut)
        else $error("master clock stuck high");
endmodule : serial_link_properties

// ==== serial_link_source.sv ====
`include "serial_rx_regs.svh"
`timescale 1ns/100ps
module serial_link_source (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    serial_link_if.source          link,
    input  wire logic              sendReq,
    input  wire logic [8:0]        sendWord,
    input  wire logic              nineBits,
    input  wire serial_rx_pkg::src_mode_t sendMode,
    input  wire logic [15:0]       bitPeriod,
    output logic                   busy
);
    import serial_rx_pkg::*;

    src_state_t  state_reg;
    src_mode_t   mode_reg;
    logic [10:0] frame_reg;
    logic [3:0]  left_reg;
    logic [15:0] cnt_reg;
    logic        data_reg;
    logic        clk_reg;
    logic        clkOe_reg;
    logic        clkPrev_reg;
    logic        clkS;

    // Device clock is foreign here
    sync_bit #(.INIT(1'b0)) uClk (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .din(link.linkClk), .dout(clkS));

    //************************************************
    // Frame building and bit timing
    //************************************************
    wire        take     = sendReq & ~busy;
    wire        isAsync  = (sendMode == SRC_ASYNC);
    wire        cntEnd   = (cnt_reg == bitPeriod - 16'h0001);
    wire        devFall  = clkPrev_reg & ~clkS;
    // Bits move on the timer, on our own falling clock, or the device's
    wire        shiftNow = (mode_reg == SRC_ASYNC)   ? cntEnd :
                           (mode_reg == SRC_CLOCKED) ? (cntEnd & clk_reg) : devFall;
    wire        lastBit  = (left_reg == 4'h1);
    // Async frame: start bit first, data LSB first, then stop
    wire [10:0] asyncFrame = nineBits ? {1'b1, sendWord, 1'b0}
                                      : {2'b11, sendWord[7:0], 1'b0};
    wire [3:0]  frameLen = isAsync ? (nineBits ? 4'hB : 4'hA)
                                   : (nineBits ? 4'h9 : 4'h8);

    //************************************************
    // Sender
    //************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= SRC_IDLE;
            mode_reg    <= SRC_ASYNC;
            frame_reg   <= 11'h7FF;
            left_reg    <= 4'h0;
            cnt_reg     <= 16'h0000;
            data_reg    <= 1'b1;
            clk_reg     <= 1'b0;
            clkOe_reg   <= 1'b0;
            clkPrev_reg <= 1'b0;
            busy        <= 1'b0;
        end else if (ce) begin
            clkPrev_reg <= clkS;
            case (state_reg)
                SRC_IDLE: begin
                    if (take) begin
                        state_reg <= SRC_SEND;
                        busy      <= 1'b1;
                        mode_reg  <= sendMode;
                        cnt_reg   <= 16'h0000;
                        clk_reg   <= 1'b0;
                        frame_reg <= isAsync ? asyncFrame : {2'b11, sendWord};
                        left_reg  <= frameLen;
                        data_reg  <= isAsync ? 1'b0 : sendWord[0];
                        clkOe_reg <= (sendMode == SRC_CLOCKED);
                    end
                end
                SRC_SEND: begin
                    cnt_reg <= cntEnd ? 16'h0000 : cnt_reg + 16'h0001;
                    // Device samples on our rising edge
                    if ((mode_reg == SRC_CLOCKED) & cntEnd) clk_reg <= ~clk_reg;
                    if (shiftNow) begin
                        if (lastBit) begin
                            state_reg <= SRC_IDLE;
                            busy      <= 1'b0;
                            data_reg  <= 1'b1;
                            clkOe_reg <= 1'b0;
                        end else begin
                            frame_reg <= {1'b1, frame_reg[10:1]};
                            data_reg  <= frame_reg[1];
                            left_reg  <= left_reg - 4'h1;
                        end
                    end
                end
                default: begin
                    state_reg <= SRC_IDLE;
                end
            endcase
        end
    end

    assign link.dataLine  = data_reg;
    assign link.srcClkOut = clk_reg;
    assign link.srcClkOe  = clkOe_reg;
endmodule : serial_link_source

// ==== serial_receiver_control.sv ====
`include "serial_rx_regs.svh"
`timescale 1ns/100ps
module serial_receiver_control (
    input  wire logic     sys_clk,
    input  wire logic     rstn,
    input  wire logic     ce,
    serial_link_if.device link,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic     s_axi_awvalid,
    output logic          s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic     s_axi_wvalid,
    output logic          s_axi_wready,
    output logic [1:0]    s_axi_bresp,
    output logic          s_axi_bvalid,
    input  wire logic     s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic     s_axi_arvalid,
    output logic          s_axi_arready,
    output logic [31:0]   s_axi_rdata,
    output logic [1:0]    s_axi_rresp,
    output logic          s_axi_rvalid,
    input  wire logic     s_axi_rready,
    output logic          rxIrq,
    output logic          wakeReq,
    output logic          vectorReq
);
    import serial_rx_pkg::*;

    logic portOn_reg, nine_reg, single_reg, cont_reg, addrDet_reg;
    logic framing_err_flag_reg, overrun_err_flag_reg, ninth_reg, done_reg, rie_reg;
    logic clock_source_select_reg, sync_reg, high_baud_select_reg, sleep_reg, gie_reg, devOe_reg;
    logic [7:0]  div_reg;
    logic [7:0]  rxByte_reg;
    logic [9:0]  awIdx_reg;
    logic [7:0]  wByte_reg;
    logic        wLane_reg;
    rx_state_t   state_reg;
    logic [15:0] cnt_reg;
    logic [3:0]  idx_reg;
    logic [8:0]  shift_reg;
    logic        genClk_reg;
    logic        clkPrev_reg;
    logic        rxS;
    logic        clkS;

    // Line and clock come from another domain
    sync_bit #(.INIT(1'b1)) uRx (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .din(link.dataLine), .dout(rxS));
    sync_bit #(.INIT(1'b0)) uClk (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .din(link.linkClk), .dout(clkS));

    //************************************************
    // Register bus decode
    //************************************************
    // Writes act once both address and data are held and no answer is pending
    wire       wrEn     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire       wrOk     = wrEn & wLane_reg;
    wire       wrStatus = wrOk & (awIdx_reg == `IDX_RX_STATUS);
    wire       wrEnable = wrOk & (awIdx_reg == `IDX_IRQ_ENABLES);
    wire       wrTx     = wrOk & (awIdx_reg == `IDX_TX_STATUS);
    wire       wrDiv    = wrOk & (awIdx_reg == `IDX_BAUD_DIV);
    wire       wrCore   = wrOk & (awIdx_reg == `IDX_CORE_CTRL);
    wire       wrHit    = (awIdx_reg == `IDX_IRQ_FLAGS) | (awIdx_reg == `IDX_RX_STATUS) |
                          (awIdx_reg == `IDX_RX_DATA) | (awIdx_reg == `IDX_IRQ_ENABLES) |
                          (awIdx_reg == `IDX_TX_STATUS) | (awIdx_reg == `IDX_BAUD_DIV) |
                          (awIdx_reg == `IDX_CORE_CTRL);
    wire       arTake   = s_axi_arvalid & s_axi_arready;
    wire [9:0] arIdx    = s_axi_araddr[11:2];
    wire       rdData   = arTake & (arIdx == `IDX_RX_DATA);
    // Order: on, nine, single, cont, addr, framing, overrun, ninth bit
    wire [7:0] statusByte = {portOn_reg, nine_reg, single_reg, cont_reg,
                             addrDet_reg, framing_err_flag_reg, overrun_err_flag_reg, ninth_reg};
    wire [7:0] txByte = ({7'h00, clock_source_select_reg} << `B_CLOCK_SOURCE_SELECT) | ({7'h00, sync_reg} << `B_SYNC) |
                        ({7'h00, high_baud_select_reg} << `B_HIGH_BAUD_SELECT) | (8'h01 << `B_TRMT);
    // Bits not held here read zero; no transmitter, so it always reads empty
    wire [7:0] rdByte =
        (arIdx == `IDX_IRQ_FLAGS)   ? ({7'h00, done_reg} << `B_RX_DONE) :
        (arIdx == `IDX_RX_STATUS)   ? statusByte :
        (arIdx == `IDX_RX_DATA)     ? rxByte_reg :
        (arIdx == `IDX_IRQ_ENABLES) ? ({7'h00, rie_reg} << `B_RX_DONE) :
        (arIdx == `IDX_TX_STATUS)   ? txByte :
        (arIdx == `IDX_BAUD_DIV)    ? div_reg :
        (arIdx == `IDX_CORE_CTRL)   ? {6'h00, gie_reg, sleep_reg} : 8'h00;
    wire       rdHit = (arIdx == `IDX_IRQ_FLAGS) | (arIdx == `IDX_RX_STATUS) |
                       (arIdx == `IDX_RX_DATA) | (arIdx == `IDX_IRQ_ENABLES) |
                       (arIdx == `IDX_TX_STATUS) | (arIdx == `IDX_BAUD_DIV) |
                       (arIdx == `IDX_CORE_CTRL);

    //************************************************
    // Receiver control terms
    //************************************************
    wire master = sync_reg & clock_source_select_reg;
    // Master clock stops in sleep; slave keeps going on the far clock
    wire rxOn = portOn_reg & ~overrun_err_flag_reg &
                (master   ? ((cont_reg | single_reg) & ~sleep_reg) :
                 sync_reg ? cont_reg :
                            (cont_reg & ~sleep_reg));
    wire [15:0] bitLen  = ({8'h00, div_reg} + 16'h0001) << (high_baud_select_reg ? `OS_HIGH : `OS_LOW);
    wire [15:0] bitLast = bitLen - 16'h0001;
    wire        cntZero = (cnt_reg == 16'h0000);
    wire [15:0] cntDec  = cnt_reg - 16'h0001;
    wire        syncEdge = sync_reg & (clock_source_select_reg ? (cntZero & ~genClk_reg)
                                                : (clkS & ~clkPrev_reg));
    wire [3:0]  lastIdx  = nine_reg ? 4'h8 : 4'h7;
    wire [8:0]  shiftIn  = {rxS, shift_reg[8:1]};
    wire        asyncDone = ~sync_reg & (state_reg == RX_STOP) & cntZero;
    wire        syncDone  = syncEdge & (idx_reg == lastIdx);
    wire        wordDone  = rxOn & (asyncDone | syncDone);
    wire [8:0]  word      = asyncDone ? shift_reg : shiftIn;
    wire [7:0]  wordByte  = nine_reg ? word[7:0] : word[8:1];
    wire        addrSkip  = ~sync_reg & nine_reg & addrDet_reg & ~word[8];
    wire        accept    = wordDone & ~addrSkip;
    // A read in the same cycle frees the buffer, so no overrun then
    wire        overrun   = accept & done_reg & ~rdData;
    wire        load      = accept & ~overrun;
    wire        wake      = done_reg & rie_reg & sleep_reg;

    //************************************************
    // Receive sequencer
    //************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= RX_IDLE;
            cnt_reg     <= 16'h0000;
            idx_reg     <= 4'h0;
            shift_reg   <= 9'h000;
            genClk_reg  <= 1'b0;
            clkPrev_reg <= 1'b0;
        end else if (ce) begin
            clkPrev_reg <= clkS;
            if (!rxOn) begin
                state_reg  <= RX_IDLE;
                cnt_reg    <= 16'h0000;
                idx_reg    <= 4'h0;
                genClk_reg <= 1'b0;
            end else if (sync_reg) begin
                state_reg <= RX_DATA;
                if (master) begin
                    cnt_reg <= cntZero ? {8'h00, div_reg} : cntDec;
                    if (cntZero) genClk_reg <= ~genClk_reg;
                end
                if (syncEdge) begin
                    shift_reg <= shiftIn;
                    idx_reg   <= syncDone ? 4'h0 : idx_reg + 4'h1;
                end
            end else begin
                case (state_reg)
                    RX_IDLE: begin
                        if (!rxS) begin
                            state_reg <= RX_START;
                            cnt_reg   <= {1'b0, bitLen[15:1]};
                        end
                    end
                    RX_START: begin
                        if (!cntZero) begin
                            cnt_reg <= cntDec;
                        end else if (!rxS) begin
                            state_reg <= RX_DATA;
                            cnt_reg   <= bitLast;
                            idx_reg   <= 4'h0;
                        end else begin
                            state_reg <= RX_IDLE; // Glitch, not a start bit
                        end
                    end
                    RX_DATA: begin
                        if (!cntZero) begin
                            cnt_reg <= cntDec;
                        end else begin
                            shift_reg <= shiftIn;
                            cnt_reg   <= bitLast;
                            idx_reg   <= idx_reg + 4'h1;
                            if (idx_reg == lastIdx) state_reg <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (!cntZero) cnt_reg <= cntDec;
                        else state_reg <= RX_IDLE;
                    end
                    default: begin
                        state_reg <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    //************************************************
    // Software registers and flags
    //************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {portOn_reg, nine_reg, single_reg, cont_reg, addrDet_reg} <= 5'h00;
            {framing_err_flag_reg, overrun_err_flag_reg, ninth_reg, done_reg, rie_reg} <= 5'h00;
            {clock_source_select_reg, sync_reg, high_baud_select_reg} <= 3'h0;
            {sleep_reg, gie_reg, devOe_reg} <= 3'h0;
            div_reg    <= `RST_BYTE;
            rxByte_reg <= `RST_BYTE;
        end else if (ce) begin
            if (wrStatus) begin
                portOn_reg  <= wByte_reg[`B_PORT_ON];
                nine_reg    <= wByte_reg[`B_NINE];
                single_reg  <= wByte_reg[`B_SINGLE];
                cont_reg    <= wByte_reg[`B_CONT];
                addrDet_reg <= wByte_reg[`B_ADDR];
            end else if (wordDone & master) begin
                single_reg  <= 1'b0;
            end
            // New overrun wins over a clear in the same cycle
            if (overrun) overrun_err_flag_reg <= 1'b1;
            else if (wrStatus & ~wByte_reg[`B_CONT]) overrun_err_flag_reg <= 1'b0;
            if (load) begin
                rxByte_reg <= wordByte;
                ninth_reg  <= nine_reg & word[8];
                framing_err_flag_reg   <= asyncDone & ~rxS;
            end
            done_reg <= load | (done_reg & ~rdData);
            if (wrEnable) rie_reg <= wByte_reg[`B_RX_DONE];
            if (wrTx) begin
                clock_source_select_reg <= wByte_reg[`B_CLOCK_SOURCE_SELECT];
                sync_reg <= wByte_reg[`B_SYNC];
                high_baud_select_reg <= wByte_reg[`B_HIGH_BAUD_SELECT];
            end
            if (wrDiv) div_reg <= wByte_reg;
            if (wrCore) gie_reg <= wByte_reg[`B_GIE];
            if (wrCore) sleep_reg <= wByte_reg[`B_SLEEP];
            else if (wake) sleep_reg <= 1'b0;
            devOe_reg <= portOn_reg & master;
        end
    end

    // Interrupt, wake and vector requests, all registered
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {rxIrq, wakeReq, vectorReq} <= 3'h0;
        end else if (ce) begin
            rxIrq     <= done_reg & rie_reg;
            wakeReq   <= wake;
            vectorReq <= wake & gie_reg;
        end
    end

    //************************************************
    // AXI4-Lite handshakes
    //************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h7;
            {s_axi_bvalid, s_axi_rvalid} <= 2'h0;
            s_axi_bresp <= `AXI_OKAY;
            s_axi_rresp <= `AXI_OKAY;
            s_axi_rdata <= 32'h00000000;
            awIdx_reg   <= 10'h000;
            wByte_reg   <= 8'h00;
            wLane_reg   <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid & s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awIdx_reg     <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid & s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wByte_reg    <= s_axi_wdata[7:0];
                wLane_reg    <= s_axi_wstrb[0];
            end
            if (wrEn) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (arTake) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rdByte};
                s_axi_rresp   <= rdHit ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Clock pin driven only as sync master
    assign link.devClkOut = genClk_reg;
    assign link.devClkOe  = devOe_reg;
endmodule : serial_receiver_control

// ==== serial_receiver_control_tb.sv ====
`timescale 1ns/100ps
module serial_receiver_control_tb;
    import serial_rx_pkg::*;
    logic sys_clk = 0, rstn = 0, ce = 1, woke = 0, wakeSeen = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, rxIrq, wakeReq, vectorReq;
    logic [1:0] bresp, rresp, rs, bs;
    logic sendReq = 0, nineBits = 0, busy;
    logic [8:0] sendWord = 0, w, e;
    src_mode_t sendMode = SRC_ASYNC;
    logic [15:0] bitPeriod = 16;
    logic [8:0] q[$];
    int failures = 0, cmp_count = 0, cyc = 0;
    serial_link_if link();
    always #12.5 sys_clk = ~sys_clk;
    serial_receiver_control u_serial_receiver_control (.sys_clk, .rstn, .ce, .link,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxIrq, .wakeReq, .vectorReq);
    serial_link_source u_serial_link_source (.sys_clk, .rstn, .ce, .link, .sendReq,
        .sendWord, .nineBits, .sendMode, .bitPeriod, .busy);
    serial_link_properties u_props (.sys_clk, .rstn, .dataLine(link.dataLine),
        .devClkOut(link.devClkOut), .devClkOe(link.devClkOe), .srcClkOut(link.srcClkOut),
        .srcClkOe(link.srcClkOe), .linkClk(link.linkClk));
    // Hang guard; also latch the short-lived wake and vector requests
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (vectorReq === 1'b1) woke <= 1'b1;
        if (wakeReq === 1'b1) wakeSeen <= 1'b1;
        if (cyc == 40000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    // Write and address go out together; each drops when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        bs = bresp;
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] x, input string n);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rs = rresp;
        chk(n, rdata, {24'h000000, x});
    endtask : rd_chk
    // Model: only words the receiver should keep are queued
    task automatic snd(input logic [8:0] v, input logic nb, input src_mode_t m, input bit keep);
        @(posedge sys_clk);
        sendWord <= v;
        nineBits <= nb;
        sendMode <= m;
        sendReq <= 1'b1;
        @(posedge sys_clk);
        sendReq <= 1'b0;
        if (keep) q.push_back(v);
    endtask : snd
    task automatic fin;
        do @(posedge sys_clk); while (busy);
        repeat (12) @(posedge sys_clk);
    endtask : fin
    task automatic rd_data;
        e = q.pop_front();
        rd_chk(12'h068, e[7:0], "data");
    endtask : rd_data
    initial begin
        void'($urandom(32'h232F6BF5));
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        rd_chk(12'h060, 8'h00, "status");
        rd_chk(12'h260, 8'h02, "txstat");
        rd_chk(12'h100, 8'h00, "unmapped");
        chk("resp", rs, 2'h2);
        wr(12'h100, 8'h55);
        chk("bresp", bs, 2'h2);
        $display("test reset done");
        wr(12'h230, 8'h20);
        wr(12'h264, 8'h00);
        wr(12'h260, 8'h04);
        wr(12'h060, 8'h90);
        w = 9'($urandom);
        snd(w, 1'b0, SRC_ASYNC, 1);
        fin();
        chk("irq", rxIrq, 1'b1);
        rd_chk(12'h030, 8'h20, "flags");
        rd_data();
        rd_chk(12'h030, 8'h00, "flags");
        snd(w, 1'b0, SRC_ASYNC, 1);
        fin();
        snd(~w, 1'b0, SRC_ASYNC, 0);
        fin();
        rd_chk(12'h060, 8'h92, "overrun");
        wr(12'h060, 8'h80);
        rd_chk(12'h060, 8'h80, "cleared");
        rd_data();
        // A nine-bit frame into an 8-bit receiver puts a low bit where the stop belongs
        wr(12'h060, 8'h90);
        snd({1'b0, ~w[7:0]}, 1'b1, SRC_ASYNC, 1);
        fin();
        rd_chk(12'h060, 8'h94, "framing");
        rd_data();
        $display("test async done");
        wr(12'h060, 8'hD8);
        snd({1'b0, w[7:0]}, 1'b1, SRC_ASYNC, 0);
        fin();
        snd({1'b1, ~w[7:0]}, 1'b1, SRC_ASYNC, 1);
        fin();
        rd_chk(12'h060, 8'hD9, "addr9");
        rd_data();
        wr(12'h060, 8'hD0);
        snd({1'b0, w[7:0]}, 1'b1, SRC_ASYNC, 1);
        fin();
        rd_chk(12'h060, 8'hD0, "ninth");
        rd_data();
        $display("test nine done");
        wr(12'h060, 8'h00);
        wr(12'h260, 8'h90);
        wr(12'h264, 8'h07);
        snd(~w, 1'b0, SRC_FOLLOW, 1);
        wr(12'h060, 8'hA0);
        fin();
        rd_chk(12'h060, 8'h80, "single");
        rd_data();
        $display("test master done");
        wr(12'h060, 8'h00);
        wr(12'h260, 8'h10);
        wr(12'h280, 8'h03);
        wr(12'h060, 8'hB0);
        bitPeriod <= 16'h0004;
        snd(w, 1'b0, SRC_CLOCKED, 1);
        fin();
        chk("wake", woke, 1'b1);
        chk("wakeReq", wakeSeen, 1'b1);
        rd_chk(12'h280, 8'h02, "sleep");
        rd_data();
        rd_chk(12'h060, 8'hB0, "slave");
        $display("test slave done");
        stop_test();
    end
endmodule : serial_receiver_control_tb

// ==== serial_rx_pkg.sv ====
package serial_rx_pkg;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_t;
    typedef enum logic [1:0] {
        SRC_ASYNC   = 2'h0,
        SRC_CLOCKED = 2'h1,
        SRC_FOLLOW  = 2'h2
    } src_mode_t;
    typedef enum logic {
        SRC_IDLE = 1'b0,
        SRC_SEND = 1'b1
    } src_state_t;
endpackage : serial_rx_pkg

// ==== serial_rx_regs.svh ====
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH
// Register indices; the byte address is four times the index
`define IDX_IRQ_FLAGS    10'h00C
`define IDX_RX_STATUS    10'h018
`define IDX_RX_DATA      10'h01A
`define IDX_IRQ_ENABLES  10'h08C
`define IDX_TX_STATUS    10'h098
`define IDX_BAUD_DIV     10'h099
`define IDX_CORE_CTRL    10'h0A0
// Field positions
`define B_PORT_ON  7
`define B_NINE     6
`define B_SINGLE   5
`define B_CONT     4
`define B_ADDR     3
`define B_RX_DONE  5
`define B_CLOCK_SOURCE_SELECT     7
`define B_SYNC     4
`define B_HIGH_BAUD_SELECT     2
`define B_TRMT     1
`define B_SLEEP    0
`define B_GIE      1
// Reset values
`define RST_BYTE       8'h00
`define RST_TX_STATUS  8'h02
// Samples per bit as a shift: 16 with high baud select, 64 without
`define OS_HIGH  4'h4
`define OS_LOW   4'h6
`define AXI_OKAY    2'h0
`define AXI_SLVERR  2'h2
`endif

// ==== sync_bit.sv ====
`timescale 1ns/100ps
module sync_bit #(
    parameter logic INIT = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;
    // Two stages; only the second stage is visible outside
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= INIT;
            dout     <= INIT;
        end else if (ce) begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule : sync_bit
